// ---- npi_ctrl.sv ----
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - Levels coded 0=10, 1=01, 2=00, 3=11; level 3 disables interrupts.
// - Four nesting levels and up to sixteen vectors at fixed positions.
// - Service starts only at the end of the current instruction.
// - Entry stacks program counter, index, accumulator and condition codes.
// - Entry loads the current level from the serviced vector's priority field; top-level loads level 3.
// - Program counter gets the vector's fixed top-of-memory address, then fetch.
// - Return pops the context, level bits included, resuming the previous level.
// - Highest software priority among pending requests wins.
// - Ties in software priority go to the highest hardware priority.
// - Hardware priorities are unique, so exactly one winner results.
// - Unserviced edge requests stay latched until they become the highest.
// - Top-level, reset and trap rank above all software priorities.
// - Reset and trap ignore the level; trap stacks, reset not; both go level 3.
// - An enabled top-level request wakes the processor from halt; reset and trap do not.
// - Trap instruction raises the trap; top-level may pre-empt a trap routine.
// - Reset wins first, its routine runs at level 3.
// - Maskable request serviced only if enabled and above current level.
// - Top-level request on a selected pin edge, serviced like a trap.
// - External lines wake from halt; sensitivity set by software.
// - Edge requests are latched and cleared on routine entry.
// - Several enabled pins of one group are ORed into one request.
// - Hardware order low to high: vectors 13 to 6, groups three to zero, vector 1, top-level.
// - Writing level-0 code into a priority field keeps its old value; reset all ones.
module npi_ctrl #(
  parameter int STACK_DEPTH = 8,
  parameter int EXT_GROUPS  = 4,
  parameter int GROUP_PINS  = 2
) (
  // Clock and reset
  input  wire logic                            sys_clk_i,
  input  wire logic                            rst_b_i,
  // APB slave
  input  wire logic                            psel_i,
  input  wire logic                            penable_i,
  input  wire logic                            pwrite_i,
  input  wire logic [npi_pkg::APB_AW-1:0]      paddr_i,
  input  wire logic [npi_pkg::REG_W-1:0]       pwdata_i,
  output logic      [npi_pkg::REG_W-1:0]       prdata_o,
  output logic                                 pready_o,
  output logic                                 pslverr_o,
  // Interrupt sources
  input  wire logic [npi_pkg::NUM_VEC-1:0]     irq_i,
  input  wire logic [EXT_GROUPS*GROUP_PINS-1:0] ext_pin_i,
  input  wire logic                            tli_pin_i,
  output logic      [npi_pkg::NUM_VEC-1:0]     ack_o,
  // CPU sequencer
  input  wire logic                            instr_end_i,
  input  wire logic                            trap_i,
  input  wire logic                            return_from_handler_i,
  input  wire logic                            halted_i,
  input  wire logic                            lvl_wr_i,
  input  wire logic [1:0]                      lvl_wdata_i,
  input  wire logic [15:0]                     pc_i,
  input  wire logic [7:0]                      x_i,
  input  wire logic [7:0]                      a_i,
  input  wire logic [7:0]                      cc_i,
  output logic                                 take_o,
  output logic                                 restore_o,
  output logic      [15:0]                     pc_o,
  output logic      [7:0]                      x_o,
  output logic      [7:0]                      a_o,
  output logic      [7:0]                      cc_o,
  output logic      [1:0]                      level_o,
  output logic                                 wake_o
);

  localparam int NV     = npi_pkg::NUM_VEC;
  localparam int EP     = EXT_GROUPS * GROUP_PINS;
  localparam int SENS_W = 2 * EXT_GROUPS + 1;
  localparam int SPW    = $clog2(STACK_DEPTH + 1);
  localparam int CTX_W  = 16 + 8 + 8 + 8 + 1;

  if (STACK_DEPTH < 1 || EXT_GROUPS < 1 || GROUP_PINS < 1 ||
      npi_pkg::EXT_VEC_BASE + EXT_GROUPS > NV || SENS_W > npi_pkg::REG_W) begin : g_bad
    $error("npi_ctrl: unsupported parameter values");
  end

  typedef struct packed {
    logic [31:0]                   prio;
    logic [SENS_W-1:0]             sense;
    logic [NV-1:0]                 en;
    logic [EP-1:0]                 ext_s1;
    logic [EP-1:0]                 ext_s2;
    logic [EP-1:0]                 ext_prev;
    logic [EXT_GROUPS-1:0]         ext_lat;
    logic                          tli_s1;
    logic                          tli_s2;
    logic                          tli_prev;
    logic                          tli_lat;
    logic [1:0]                    level;
    logic                          in_trap;
    logic                          reset_pend;
    logic [SPW-1:0]                sp;
    logic [STACK_DEPTH-1:0][CTX_W-1:0] stack;
    logic                          take;
    logic                          restore;
    logic [15:0]                   pc;
    logic [7:0]                    x;
    logic [7:0]                    a;
    logic [7:0]                    cc;
    logic [NV-1:0]                 ack;
    logic                          wake;
    logic                          pready;
    logic                          pslverr;
    logic [31:0]                   prdata;
  } npi_state_t;

  npi_state_t s_r;
  npi_state_t s_nxt;

  // Level code to rank 0..3
  function automatic logic [1:0] lvl_rank(input logic [1:0] code);
    case (code)
      npi_pkg::LVL0: lvl_rank = 2'h0;
      npi_pkg::LVL1: lvl_rank = 2'h1;
      npi_pkg::LVL2: lvl_rank = 2'h2;
      default:       lvl_rank = 2'h3;
    endcase
  endfunction

  // Address decode shared by read and write paths
  function automatic logic reg_ok(input logic [npi_pkg::APB_AW-1:0] addr);
    reg_ok = (addr[1:0] == 2'h0) && (addr[npi_pkg::APB_AW-1:5] == '0);
  endfunction

  // Level-0 codes in a written byte leave the stored field alone
  function automatic logic [7:0] prio_merge(input logic [7:0] old_v, input logic [7:0] new_v);
    prio_merge = old_v;
    for (int f = 0; f < 4; f++) begin
      if (new_v[2*f +: 2] != npi_pkg::LVL0) begin
        prio_merge[2*f +: 2] = new_v[2*f +: 2];
      end
    end
  endfunction

  logic [NV-1:0]         pend;
  logic [NV-1:0]         elig;
  logic [EXT_GROUPS-1:0] ext_set;
  logic                  tli_set;
  logic                  found;
  logic [npi_pkg::VIDX_W-1:0] best_v;
  logic [2:0]            best_rank;

  // Edge detection, request gathering and arbitration
  always_comb begin
    logic [EP-1:0] rise;
    logic [EP-1:0] fall;
    logic [2:0]    eff;
    rise = s_r.ext_s2 & ~s_r.ext_prev;
    fall = ~s_r.ext_s2 & s_r.ext_prev;
    eff  = 3'h0;
    pend = irq_i;
    for (int g = 0; g < EXT_GROUPS; g++) begin
      case (s_r.sense[2*g +: 2])
        npi_pkg::SENS_RISE: ext_set[g] = |rise[g*GROUP_PINS +: GROUP_PINS];
        npi_pkg::SENS_FALL: ext_set[g] = |fall[g*GROUP_PINS +: GROUP_PINS];
        npi_pkg::SENS_BOTH: ext_set[g] = |(rise[g*GROUP_PINS +: GROUP_PINS] |
                                           fall[g*GROUP_PINS +: GROUP_PINS]);
        default:            ext_set[g] = 1'b0;
      endcase
      // Low-level sense is not latched: it requests while any pin stays low
      pend[npi_pkg::EXT_VEC_BASE + g] = irq_i[npi_pkg::EXT_VEC_BASE + g] | s_r.ext_lat[g] |
          ((s_r.sense[2*g +: 2] == npi_pkg::SENS_LOW) &&
           !(&s_r.ext_s2[g*GROUP_PINS +: GROUP_PINS]));
    end
    tli_set = s_r.sense[SENS_W-1] ? (s_r.tli_s2 & ~s_r.tli_prev)
                                  : (~s_r.tli_s2 & s_r.tli_prev);
    pend[npi_pkg::VEC_TLI] = irq_i[npi_pkg::VEC_TLI] | s_r.tli_lat;
    for (int v = 0; v < NV; v++) begin
      if (v == npi_pkg::VEC_TLI) begin
        elig[v] = s_r.en[v] && pend[v] &&
                  (s_r.level != npi_pkg::LVL3 || s_r.in_trap);
      end else begin
        elig[v] = s_r.en[v] && pend[v] &&
                  (lvl_rank(s_r.prio[2*v +: 2]) > lvl_rank(s_r.level));
      end
    end
    found     = 1'b0;
    best_v    = '0;
    best_rank = 3'h0;
    // Walk from lowest hardware priority up so ties land on the lower index
    for (int v = NV - 1; v >= 0; v--) begin
      eff = (v == npi_pkg::VEC_TLI) ? 3'h4 : {1'b0, lvl_rank(s_r.prio[2*v +: 2])};
      if (elig[v] && (!found || eff >= best_rank)) begin
        found     = 1'b1;
        best_v    = npi_pkg::VIDX_W'(v);
        best_rank = eff;
      end
    end
  end

  always_comb begin
    logic [2:0]       ridx;
    logic [31:0]      rval;
    logic [CTX_W-1:0] top;
    logic [SPW-1:0]   sp_m1;
    s_nxt        = s_r;
    ridx         = paddr_i[4:2];
    rval         = '0;
    sp_m1        = s_r.sp - 1'b1;
    top          = s_r.stack[sp_m1];
    s_nxt.take   = 1'b0;
    s_nxt.restore = 1'b0;
    s_nxt.ack    = '0;
    // Pins pass two flops before any logic sees them
    s_nxt.ext_s1   = ext_pin_i;
    s_nxt.ext_s2   = s_r.ext_s1;
    s_nxt.ext_prev = s_r.ext_s2;
    s_nxt.tli_s1   = tli_pin_i;
    s_nxt.tli_s2   = s_r.tli_s1;
    s_nxt.tli_prev = s_r.tli_s2;

    if (s_r.reset_pend) begin
      s_nxt.reset_pend = 1'b0;
      s_nxt.take       = 1'b1;
      s_nxt.pc         = npi_pkg::VEC_RESET;
      s_nxt.level      = npi_pkg::LVL3;
      s_nxt.in_trap    = 1'b0;
    end else if (instr_end_i && (trap_i || found)) begin
      // A full stack drops the push silently, as the processor would overflow
      if (s_r.sp < SPW'(STACK_DEPTH)) begin
        s_nxt.stack[s_r.sp] = {pc_i, x_i, a_i, cc_i[7:6], s_r.level[1], cc_i[4],
                               s_r.level[0], cc_i[2:0], s_r.in_trap};
        s_nxt.sp = s_r.sp + 1'b1;
      end
      s_nxt.take = 1'b1;
      if (trap_i) begin
        s_nxt.pc      = npi_pkg::VEC_TRAP;
        s_nxt.level   = npi_pkg::LVL3;
        s_nxt.in_trap = 1'b1;
      end else begin
        s_nxt.pc = npi_pkg::VEC_BASE - 16'(npi_pkg::VEC_STEP * best_v);
        s_nxt.level = (best_v == npi_pkg::VIDX_W'(npi_pkg::VEC_TLI)) ? npi_pkg::LVL3
                      : s_r.prio[2*best_v +: 2];
        s_nxt.in_trap = 1'b0;
        s_nxt.ack[best_v] = 1'b1;
      end
    end else if (return_from_handler_i && s_r.sp != '0) begin
      s_nxt.sp      = sp_m1;
      s_nxt.restore = 1'b1;
      {s_nxt.pc, s_nxt.x, s_nxt.a, s_nxt.cc, s_nxt.in_trap} = top;
      s_nxt.level   = {top[1 + npi_pkg::CC_HI_POS], top[1 + npi_pkg::CC_LO_POS]};
    end else if (lvl_wr_i) begin
      s_nxt.level = lvl_wdata_i;
    end

    // Set wins over the entry-time clear
    for (int g = 0; g < EXT_GROUPS; g++) begin
      s_nxt.ext_lat[g] = (s_r.ext_lat[g] & ~s_nxt.ack[npi_pkg::EXT_VEC_BASE + g])
                         | ext_set[g];
    end
    s_nxt.tli_lat = (s_r.tli_lat & ~s_nxt.ack[npi_pkg::VEC_TLI]) | tli_set;
    s_nxt.wake = halted_i && |(pend & s_r.en &
        ((NV)'(((1 << EXT_GROUPS) - 1) << npi_pkg::EXT_VEC_BASE) | (NV)'(1)));

    // APB: one wait state, write lands on the completing edge
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;
    if (psel_i && penable_i && !s_r.pready) begin
      case (ridx)
        npi_pkg::IDX_SENSE:   rval = 32'(s_r.sense);
        npi_pkg::IDX_ENABLE:  rval = 32'(s_r.en);
        npi_pkg::IDX_PENDING: rval = 32'(pend);
        npi_pkg::IDX_STATUS:  rval = 32'({s_r.sp, s_r.in_trap, s_r.level});
        default:              rval = {24'h000000, s_r.prio[8*ridx[1:0] +: 8]};
      endcase
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = !reg_ok(paddr_i);
      s_nxt.prdata  = (pwrite_i || !reg_ok(paddr_i)) ? 32'h00000000 : rval;
    end
    if (psel_i && penable_i && s_r.pready && pwrite_i && reg_ok(paddr_i)) begin
      case (ridx)
        npi_pkg::IDX_SENSE:   s_nxt.sense = pwdata_i[SENS_W-1:0];
        npi_pkg::IDX_ENABLE:  s_nxt.en = pwdata_i[NV-1:0];
        npi_pkg::IDX_PENDING: s_nxt.en = s_r.en;
        npi_pkg::IDX_STATUS:  s_nxt.en = s_r.en;
        npi_pkg::IDX_PRIO3:
          s_nxt.prio[31:24] = (prio_merge(s_r.prio[31:24], pwdata_i[7:0]) &
                               ~npi_pkg::PRIO3_RO_MASK) |
                              (s_r.prio[31:24] & npi_pkg::PRIO3_RO_MASK);
        default:
          s_nxt.prio[8*ridx[1:0] +: 8] = prio_merge(s_r.prio[8*ridx[1:0] +: 8],
                                                    pwdata_i[7:0]);
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r            <= '0;
      s_r.prio       <= {4{npi_pkg::PRIO_RST}};
      s_r.level      <= npi_pkg::LVL3;
      s_r.reset_pend <= 1'b1;
      s_r.ext_s1     <= '1;
      s_r.ext_s2     <= '1;
      s_r.ext_prev   <= '1;
      s_r.tli_s1     <= 1'b1;
      s_r.tli_s2     <= 1'b1;
      s_r.tli_prev   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata_o  = s_r.prdata;
  assign pready_o  = s_r.pready;
  assign pslverr_o = s_r.pslverr;
  assign ack_o     = s_r.ack;
  assign take_o    = s_r.take;
  assign restore_o = s_r.restore;
  assign pc_o      = s_r.pc;
  assign x_o       = s_r.x;
  assign a_o       = s_r.a;
  assign cc_o      = s_r.cc;
  assign level_o   = s_r.level;
  assign wake_o    = s_r.wake;

  default clocking npi_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  chk_reset_entry: assert property (s_r.reset_pend |=> take_o && pc_o == npi_pkg::VEC_RESET
      && level_o == npi_pkg::LVL3 && s_r.sp == '0)
    else $error("reset entry wrong");
  chk_take_boundary: assert property (take_o && pc_o != npi_pkg::VEC_RESET
      |-> $past(instr_end_i))
    else $error("service began mid instruction");
  chk_trap_entry: assert property (!s_r.reset_pend && instr_end_i && trap_i |=> take_o
      && pc_o == npi_pkg::VEC_TRAP && level_o == npi_pkg::LVL3 && ack_o == '0)
    else $error("trap entry wrong");
  chk_context_push: assert property (take_o && pc_o != npi_pkg::VEC_RESET |->
      s_r.sp == $past(s_r.sp) + 1'b1 || $past(s_r.sp) == SPW'(STACK_DEPTH))
    else $error("context not stacked");
  chk_level_raise: assert property (take_o && |ack_o[NV-1:1] |->
      lvl_rank(level_o) > lvl_rank($past(level_o)))
    else $error("serviced without higher priority");
  chk_return_from_handler_restore: assert property (return_from_handler_i && s_r.sp != '0 && !s_r.reset_pend &&
      !(instr_end_i && (trap_i || found)) |=> restore_o && s_r.sp == $past(s_r.sp) - 1'b1)
    else $error("return did not pop context");
  chk_ack_single: assert property ($onehot0(ack_o))
    else $error("more than one acknowledge");
  for (genvar v = 1; v < NV; v++) begin : g_chk
    chk_level_load: assert property (take_o && ack_o[v] |->
        level_o == $past(s_r.prio[2*v +: 2]))
      else $error("entry level not loaded from field");
    chk_prio_nolvl0: assert property (s_r.prio[2*v +: 2] != npi_pkg::LVL0)
      else $error("priority field holds level 0");
  end

endmodule

// ---- npi_pkg.sv ----
package npi_pkg;

  // Software level codes as held in the level bits
  localparam logic [1:0]  LVL0          = 2'h2;
  localparam logic [1:0]  LVL1          = 2'h1;
  localparam logic [1:0]  LVL2          = 2'h0;
  localparam logic [1:0]  LVL3          = 2'h3;

  // Vector table
  localparam int          NUM_VEC       = 14;
  localparam int          VIDX_W        = 4;
  localparam int          VEC_TLI       = 0;
  localparam logic [15:0] VEC_RESET     = 16'hfffe;
  localparam logic [15:0] VEC_TRAP      = 16'hfffc;
  localparam logic [15:0] VEC_BASE      = 16'hfffa;
  localparam logic [15:0] VEC_STEP      = 16'h0002;

  // Level bit positions in the condition code register
  localparam int          CC_HI_POS     = 5;
  localparam int          CC_LO_POS     = 3;

  // Register map, word indices
  localparam int          APB_AW        = 8;
  localparam int          REG_W         = 32;
  localparam logic [2:0]  IDX_PRIO3     = 3'h3;
  localparam logic [2:0]  IDX_SENSE     = 3'h4;
  localparam logic [2:0]  IDX_ENABLE    = 3'h5;
  localparam logic [2:0]  IDX_PENDING   = 3'h6;
  localparam logic [2:0]  IDX_STATUS    = 3'h7;
  localparam logic [7:0]  PRIO_RST      = 8'hff;
  localparam logic [7:0]  PRIO3_RO_MASK = 8'hf0;

  // External sense codes, one field per group; top-level edge bit above them
  localparam logic [1:0]  SENS_LOW      = 2'h0;
  localparam logic [1:0]  SENS_RISE     = 2'h1;
  localparam logic [1:0]  SENS_FALL     = 2'h2;
  localparam logic [1:0]  SENS_BOTH     = 2'h3;
  localparam int          EXT_VEC_BASE  = 2;

endpackage

// ---- npi_cpu_model.sv ----
`timescale 1ns/1ps
module npi_cpu_model (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  // Bench commands
  input  wire logic       trap_req_i,
  input  wire logic       return_from_handler_req_i,
  input  wire logic       halted_i,
  input  wire logic [1:0] gap_i,
  input  wire logic [1:0] level_i,
  // Sequencer side
  output logic            instr_end_o,
  output logic            trap_o,
  output logic            return_from_handler_o,
  output logic [7:0]      cc_o
);
  logic [1:0] cnt_r;
  logic       trap_pend_r;
  logic       return_from_handler_pend_r;

  // Level bits mirror the live level, so a push saves the level in force
  assign cc_o = {2'b11, level_i[1], 1'b0, level_i[0], 3'b010};

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r       <= 2'h0;
      trap_pend_r <= 1'b0;
      return_from_handler_pend_r <= 1'b0;
      instr_end_o <= 1'b0;
      trap_o      <= 1'b0;
      return_from_handler_o      <= 1'b0;
    end else begin
      instr_end_o <= 1'b0;
      trap_o      <= 1'b0;
      return_from_handler_o      <= 1'b0;
      // A halted core finishes no instruction
      if (halted_i) begin
        cnt_r <= 2'h0;
      end else if (cnt_r < gap_i) begin
        cnt_r <= cnt_r + 2'h1;
      end else begin
        cnt_r       <= 2'h0;
        instr_end_o <= 1'b1;
        trap_o      <= trap_pend_r;
        return_from_handler_o      <= return_from_handler_pend_r & ~trap_pend_r;
        trap_pend_r <= 1'b0;
        if (!trap_pend_r) begin
          return_from_handler_pend_r <= 1'b0;
        end
      end
      // Placed last so a request in the firing cycle is not lost
      if (trap_req_i) begin
        trap_pend_r <= 1'b1;
      end
      if (return_from_handler_req_i) begin
        return_from_handler_pend_r <= 1'b1;
      end
    end
  end
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        tli_pin = 1'b1, halted = 1'b0, lvl_wr = 1'b0, trap_req = 1'b0, return_from_handler_req = 1'b0;
  logic        pready, pslverr, instr_end, trap, return_from_handler, take, restore, wake, err;
  logic [1:0]  gap = 2'h0, lvl_wdata = 2'h0, level;
  logic [7:0]  paddr = 8'h00, ext_pin = 8'hff, x = 8'h5a, a = 8'ha5, cc, x_q, a_q, cc_q;
  logic [13:0] irq = 14'h0, ack;
  logic [15:0] pc = 16'h1234, pc_q;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  prio [4] = '{default: 8'hff};
  int          error_cnt = 0, n_compared = 0;

  always #5 clk = ~clk;

  npi_ctrl u_dut (
    .sys_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .irq_i(irq), .ext_pin_i(ext_pin),
    .tli_pin_i(tli_pin), .ack_o(ack), .instr_end_i(instr_end), .trap_i(trap),
    .return_from_handler_i(return_from_handler), .halted_i(halted), .lvl_wr_i(lvl_wr), .lvl_wdata_i(lvl_wdata),
    .pc_i(pc), .x_i(x), .a_i(a), .cc_i(cc), .take_o(take), .restore_o(restore),
    .pc_o(pc_q), .x_o(x_q), .a_o(a_q), .cc_o(cc_q), .level_o(level), .wake_o(wake));

  npi_cpu_model u_cpu (
    .sys_clk_i(clk), .rst_b_i(rst_b), .trap_req_i(trap_req), .return_from_handler_req_i(return_from_handler_req),
    .halted_i(halted), .gap_i(gap), .level_i(level), .instr_end_o(instr_end),
    .trap_o(trap), .return_from_handler_o(return_from_handler), .cc_o(cc));

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin chk(pready, 1'b1); conclude(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic set_prio(input int v, input logic [1:0] code);
    prio[v/4][2*(v%4) +: 2] = code;
    apb(1'b1, 8'(4 * (v / 4)), {24'h0, prio[v/4]});
  endtask

  task automatic set_level(input logic [1:0] code);
    lvl_wdata <= code;
    lvl_wr <= 1'b1;
    @(posedge clk);
    lvl_wr <= 1'b0;
  endtask

  task automatic expect_take(input logic [15:0] pcx, input logic [1:0] lvl,
                             input logic [13:0] ackx);
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (take !== 1'b1 && n < 100);
    if (take !== 1'b1) begin chk(take, 1'b1); conclude(); end
    chk(pc_q, pcx);
    chk(level, lvl);
    chk(ack, ackx);
  endtask

  task automatic do_return_from_handler(input logic [1:0] lvl);
    int n;
    return_from_handler_req <= 1'b1;
    @(posedge clk);
    return_from_handler_req <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (restore !== 1'b1 && n < 100);
    if (restore !== 1'b1) begin chk(restore, 1'b1); conclude(); end
    chk({pc_q, x_q, a_q}, {16'h1234, 8'h5a, 8'ha5});
    chk(cc_q, {2'b11, lvl[1], 1'b0, lvl[0], 3'b010});
    chk(level, lvl);
  endtask

  task automatic t_reset();
    expect_take(16'hfffe, npi_pkg::LVL3, 14'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'hff);
    end
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_prio();
    apb(1'b1, 8'h00, 32'hcf);
    apb(1'b1, 8'h00, 32'h64);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h44);
    apb(1'b1, 8'h00, 32'hff);
    apb(1'b1, 8'h0c, 32'h00);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'hf0);
    apb(1'b1, 8'h0c, 32'hff);
    $display("test prio done");
  endtask

  task automatic t_mask();
    set_prio(1, npi_pkg::LVL1);
    apb(1'b1, 8'h14, 32'h2);
    set_level(npi_pkg::LVL0);
    irq[1] <= 1'b1;
    expect_take(16'hfff8, npi_pkg::LVL1, 14'h2);
    irq[1] <= 1'b0;
    do_return_from_handler(npi_pkg::LVL0);
    $display("test mask done");
  endtask

  task automatic t_arb();
    logic seen;
    seen = 1'b0;
    gap <= 2'h3;
    set_prio(6, npi_pkg::LVL1);
    set_prio(9, npi_pkg::LVL1);
    apb(1'b1, 8'h14, 32'h240);
    irq <= 14'h240;
    expect_take(16'hffee, npi_pkg::LVL1, 14'h40);
    irq[6] <= 1'b0;
    repeat (30) begin
      @(posedge clk);
      if (take === 1'b1) seen = 1'b1;
    end
    chk(seen, 1'b0);
    do_return_from_handler(npi_pkg::LVL0);
    expect_take(16'hffe8, npi_pkg::LVL1, 14'h200);
    irq[9] <= 1'b0;
    do_return_from_handler(npi_pkg::LVL0);
    set_prio(9, npi_pkg::LVL2);
    irq <= 14'h240;
    expect_take(16'hffe8, npi_pkg::LVL2, 14'h200);
    irq <= 14'h0;
    do_return_from_handler(npi_pkg::LVL0);
    gap <= 2'h0;
    $display("test arb done");
  endtask

  task automatic t_trap_tli();
    set_level(npi_pkg::LVL3);
    apb(1'b1, 8'h14, 32'h1);
    trap_req <= 1'b1;
    @(posedge clk);
    trap_req <= 1'b0;
    expect_take(16'hfffc, npi_pkg::LVL3, 14'h0);
    // Falling edge is the reset choice; top-level pre-empts the trap routine at level 3
    tli_pin <= 1'b0;
    expect_take(16'hfffa, npi_pkg::LVL3, 14'h1);
    tli_pin <= 1'b1;
    do_return_from_handler(npi_pkg::LVL3);
    do_return_from_handler(npi_pkg::LVL3);
    $display("test trap done");
  endtask

  task automatic t_ext();
    apb(1'b1, 8'h10, {30'h0, npi_pkg::SENS_RISE});
    apb(1'b1, 8'h14, 32'h4);
    halted <= 1'b1;
    ext_pin[1] <= 1'b0;
    repeat (5) @(posedge clk);
    ext_pin[1] <= 1'b1;
    repeat (6) @(posedge clk);
    chk(wake, 1'b1);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd[2], 1'b1);
    halted <= 1'b0;
    set_level(npi_pkg::LVL0);
    expect_take(16'hfff6, npi_pkg::LVL3, 14'h4);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd[2], 1'b0);
    do_return_from_handler(npi_pkg::LVL0);
    // Group 1 low level is not latched; group 2 falling edge is held
    apb(1'b1, 8'h10, 32'h21);
    ext_pin[2] <= 1'b0;
    ext_pin[5] <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd[4:3], 2'h3);
    ext_pin[2] <= 1'b1;
    ext_pin[5] <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd[4:3], 2'h2);
    $display("test ext done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_prio();
    t_mask();
    t_arb();
    t_trap_tli();
    t_ext();
    conclude();
  end
endmodule
